// file: aofs_pkg.sv
package aofs_pkg;
   localparam int NUM_OUT    = 4;
   localparam int CODE_W     = 5;
   localparam int SPD_W      = 16;
   localparam int TIME_W     = 16;
   localparam int CLK_HZ     = 50000000;
   // Control tick period in microseconds; one tick per 100 us
   localparam int TICK_US    = 100;
   localparam int TICK_CYC   = (CLK_HZ / 1000000) * TICK_US;
   // Timer settings count in 0.1 s units, contactor in ms
   localparam int TIMER_UNIT_MS = 100;
   localparam int TICKS_PER_MS  = 1000 / TICK_US;
   localparam logic [15:0] TIMER_DLY_DEF = 16'h0001;
   localparam logic [15:0] MC_DLY_DEF    = 16'h03e8;
   // Bands are in 0.1 percent of full scale
   localparam logic [15:0] BAND_DEF      = 16'h0005;
   localparam int BAND_DIV  = 1000;

   typedef enum logic [4:0] {
      FN_UNUSED  = 5'h00, FN_READY  = 5'h01, FN_ZERO   = 5'h02, FN_SPDSGN = 5'h03,
      FN_SPDABS  = 5'h04, FN_ARRIVE = 5'h05, FN_TIMER  = 5'h06, FN_UV     = 5'h07,
      FN_RUN     = 5'h08, FN_REGEN  = 5'h09, FN_OH     = 5'h0a, FN_AGREE  = 5'h0b,
      FN_TRQ     = 5'h0c, FN_TRQLIM = 5'h0d, FN_OVL    = 5'h0e, FN_STOP   = 5'h0f,
      FN_MC      = 5'h10, FN_FAN    = 5'h11, FN_LLS    = 5'h12, FN_STEADY = 5'h13,
      FN_BRAKE   = 5'h14, FN_ELEV1  = 5'h15, FN_ELEV2  = 5'h16, FN_ELEV3  = 5'h17
   } aofs_func_t;

   typedef enum logic [1:0] {
      CM_VF = 2'h0, CM_SLIP = 2'h1, CM_SPD_IM = 2'h2, CM_SPD_PM = 2'h3
   } aofs_ctrl_mode_t;

   typedef enum logic [1:0] {
      MC_OPEN = 2'h0, MC_CLOSING = 2'h1, MC_CLOSED = 2'h2, MC_OPENING = 2'h3
   } aofs_mc_state_t;

   typedef struct packed {
      logic ready, faultTrip, batteryRun, undervoltageWarning, running, stopped;
      logic regenerating, overheatWarning, overload, trqAtLimit, fanWarning;
      logic lightLoadSearchActive, brakeOpen, runCommand, ramping;
      logic [2:0] elevFlags;
   } aofs_status_t;

   typedef struct packed {
      logic signed [SPD_W-1:0] motorSpeed;
      logic signed [SPD_W-1:0] speedRef;
      logic        [SPD_W-1:0] maxSpeedSetting;
      logic        [SPD_W-1:0] torque;
   } aofs_meas_t;

   typedef struct packed {
      logic        [SPD_W-1:0] standstillLevel;
      logic        [15:0]      standstillBand;
      logic signed [SPD_W-1:0] speedThreshold;
      logic        [15:0]      speedThresholdBand;
      logic        [15:0]      arrivalBand;
      logic        [15:0]      agreementBand;
      logic        [SPD_W-1:0] torqueThreshold;
      logic        [15:0]      torqueThresholdBand;
      logic        [TIME_W-1:0] timerAssertDelay;
      logic        [TIME_W-1:0] timerReleaseDelay;
      logic        [TIME_W-1:0] contactorCloseDelay;
      logic        [TIME_W-1:0] contactorOpenDelay;
   } aofs_cfg_t;
endpackage : aofs_pkg

// file: aofs_selector.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Each terminal is driven while its selected condition holds, or while it is false if its polarity bit is set.
// - Function codes 1 to 20 choose ready through brake conditions.
// - Zero speed, agreement, torque and torque limit need closed-loop speed mode.
// - Codes 21 to 23 need the elevator module and elevator application.
// - An unused terminal stays at its polarity bit whatever the drive does.
// - Ready follows drive readiness and drops at once on a fault trip.
// - Ready stays on during battery running despite low link voltage.
// - Zero speed compares speed to a level with band of maximum speed.
// - Speed level detection is signed for code 3, magnitude for code 4.
// - Speed reached when speed is within a band of its reference.
// - Speed agreement flags speed leaving the reference band while ramping.
// - Timer output follows timer input with on and off delays.
// - Low voltage output follows the undervoltage warning.
// - Running output holds while the motor is driven.
// - Regenerating output is unavailable in open-loop control modes.
// - Overheat output follows the overheat warning.
// - Torque detection compares torque with a level and band.
// - Torque limit output holds while the speed controller saturates.
// - Stopped output holds in the stop state.
// - Contactor closes a delay before running and opens a delay after.
// - Without a contactor terminal both contactor delays are zero.
// - Steady output holds while running without ramping.
// - A polarity bit per terminal turns it normally closed.
module aofs_selector
   import aofs_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   input  wire logic                        clk_sys,
   input  wire logic                        resetn,
   input  wire aofs_func_t                  funcSel [NUM_OUT],
   input  wire logic [NUM_OUT-1:0]          polarityInvert,
   input  wire aofs_ctrl_mode_t             ctrlMode,
   input  wire logic                        elevModuleFitted,
   input  wire logic                        appElevator,
   input  wire aofs_status_t                status,
   input  wire aofs_meas_t                  meas,
   input  wire aofs_cfg_t                   cfg,
   input  wire logic                        timerInput,
   output logic [NUM_OUT-1:0]               auxOutput,
   output logic                             runPermit,
   output logic [TIME_W-1:0]                contactorCloseEff,
   output logic [TIME_W-1:0]                contactorOpenEff
);
   initial begin
      if (TICK_CYCLES < 2) $error("TICK_CYCLES must be at least 2");
   end

   logic [1:0]  rstSync_q;
   logic        rstn;
   logic [31:0] tickCnt_q;
   logic        tick;
   logic [1:0]  timerSync_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) rstSync_q <= 2'h0;
      else rstSync_q <= {rstSync_q[0], 1'b1};
   end
   assign rstn = rstSync_q[1];

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) tickCnt_q <= 32'h0;
      else if (tick) tickCnt_q <= 32'h0;
      else tickCnt_q <= tickCnt_q + 32'h1;
   end
   assign tick = (tickCnt_q == 32'(TICK_CYCLES - 1));

   // Timer input arrives from a pin
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) timerSync_q <= 2'h0;
      else timerSync_q <= {timerSync_q[0], timerInput};
   end

   // Band in 0.1 % units of a full-scale value
   function automatic logic [SPD_W-1:0] bandOf(input logic [15:0] band,
                                               input logic [SPD_W-1:0] full);
      logic [31:0] prod;
      prod = 32'(band) * 32'(full);
      return SPD_W'(prod / 32'(BAND_DIV));
   endfunction

   function automatic logic inBand(input logic signed [SPD_W:0] meas_v,
                                   input logic signed [SPD_W:0] lvl,
                                   input logic [SPD_W-1:0] bnd);
      logic signed [SPD_W+1:0] diff;
      logic signed [SPD_W+1:0] lim;
      diff = (SPD_W+2)'(meas_v) - (SPD_W+2)'(lvl);
      // Signed limit, else the compare turns unsigned and a negative diff fails
      lim  = signed'({2'b00, bnd});
      return (diff <= lim) && (diff >= -lim);
   endfunction

   function automatic logic [SPD_W:0] absOf(input logic signed [SPD_W-1:0] v);
      logic signed [SPD_W:0] w;
      w = (SPD_W+1)'(v);
      return (w < 0) ? (SPD_W+1)'(-w) : w;
   endfunction

   wire logic closedLoop = (ctrlMode == CM_SPD_IM) || (ctrlMode == CM_SPD_PM);
   wire logic openLoop   = (ctrlMode == CM_VF) || (ctrlMode == CM_SLIP);
   wire logic elevOk     = elevModuleFitted && appElevator;
   wire logic [SPD_W-1:0] fullSpd = meas.maxSpeedSetting;
   wire logic signed [SPD_W:0] spdS = (SPD_W+1)'(meas.motorSpeed);
   wire logic signed [SPD_W:0] refS = (SPD_W+1)'(meas.speedRef);

   // Combinational band checks, registered once per tick
   wire logic zeroHit  = inBand(absOf(meas.motorSpeed), {1'b0, cfg.standstillLevel},
                                bandOf(cfg.standstillBand, fullSpd));
   wire logic sgnHit   = inBand(spdS, (SPD_W+1)'(cfg.speedThreshold),
                                bandOf(cfg.speedThresholdBand, fullSpd));
   wire logic absHit   = inBand(absOf(meas.motorSpeed), absOf(cfg.speedThreshold),
                                bandOf(cfg.speedThresholdBand, fullSpd));
   wire logic arrHit   = inBand(spdS, refS, bandOf(cfg.arrivalBand, fullSpd));
   wire logic agrHit   = inBand(spdS, refS, bandOf(cfg.agreementBand, fullSpd));
   wire logic trqHit   = inBand({1'b0, meas.torque}, {1'b0, cfg.torqueThreshold},
                                bandOf(cfg.torqueThresholdBand, 16'h03e8));

   logic zero_q, sgn_q, abs_q, arr_q, agr_q, trq_q;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) {zero_q, sgn_q, abs_q, arr_q, agr_q, trq_q} <= 6'h0;
      else if (tick) {zero_q, sgn_q, abs_q, arr_q, agr_q, trq_q} <=
         {zeroHit, sgnHit, absHit, arrHit, agrHit, trqHit};
   end

   // Timer function: delays counted in ticks
   logic        timerOut_q;
   logic [31:0] timerCnt_q;
   wire logic   timerIn    = timerSync_q[1];
   wire logic [31:0] onTicks  = 32'(cfg.timerAssertDelay)
                                * 32'(TIMER_UNIT_MS * TICKS_PER_MS);
   wire logic [31:0] offTicks = 32'(cfg.timerReleaseDelay)
                                * 32'(TIMER_UNIT_MS * TICKS_PER_MS);
   wire logic [31:0] timerTarget = timerIn ? onTicks : offTicks;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         timerOut_q <= 1'b0;
         timerCnt_q <= 32'h0;
      end else if (timerIn == timerOut_q) begin
         timerCnt_q <= 32'h0;
      end else if (tick) begin
         if (timerCnt_q + 32'h1 >= timerTarget) begin
            timerOut_q <= timerIn;
            timerCnt_q <= 32'h0;
         end else begin
            timerCnt_q <= timerCnt_q + 32'h1;
         end
      end
   end

   // Contactor sequencing
   logic [NUM_OUT-1:0] mcAssignedVec;
   always_comb begin
      mcAssignedVec = '0;
      for (int i = 0; i < NUM_OUT; i++) mcAssignedVec[i] = (funcSel[i] == FN_MC);
   end
   wire logic mcUsed = |mcAssignedVec;
   wire logic [TIME_W-1:0] closeDly = mcUsed ? cfg.contactorCloseDelay : '0;
   wire logic [TIME_W-1:0] openDly  = mcUsed ? cfg.contactorOpenDelay  : '0;

   aofs_mc_state_t mcState_q, mcState_d;
   logic [31:0]    mcCnt_q;
   wire logic [31:0] mcTarget = 32'(mcState_q == MC_CLOSING ? closeDly : openDly)
                                * 32'(TICKS_PER_MS);
   wire logic mcDone = tick && (mcCnt_q + 32'h1 >= mcTarget);
   always_comb begin
      mcState_d = mcState_q;
      unique case (mcState_q)
         MC_OPEN:    if (status.runCommand) mcState_d = MC_CLOSING;
         MC_CLOSING: if (!status.runCommand) mcState_d = MC_OPEN;
                     else if (mcDone || closeDly == '0) mcState_d = MC_CLOSED;
         MC_CLOSED:  if (!status.runCommand && !status.running) mcState_d = MC_OPENING;
         MC_OPENING: if (status.runCommand) mcState_d = MC_CLOSED;
                     else if (mcDone || openDly == '0) mcState_d = MC_OPEN;
      endcase
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mcState_q <= MC_OPEN;
         mcCnt_q   <= 32'h0;
      end else begin
         mcState_q <= mcState_d;
         if (mcState_d != mcState_q) mcCnt_q <= 32'h0;
         else if (tick) mcCnt_q <= mcCnt_q + 32'h1;
      end
   end
   wire logic mcClosed = (mcState_q != MC_OPEN);
   wire logic permitD  = (mcState_d == MC_CLOSED);

   // Per-terminal condition decode
   function automatic logic condOf(input aofs_func_t f);
      logic c;
      c = 1'b0;
      case (f)
         FN_READY:  c = status.ready && !status.faultTrip
                        && (!status.undervoltageWarning || status.batteryRun);
         FN_ZERO:   c = closedLoop && zero_q;
         FN_SPDSGN: c = sgn_q;
         FN_SPDABS: c = abs_q;
         FN_ARRIVE: c = arr_q;
         FN_TIMER:  c = timerOut_q;
         FN_UV:     c = status.undervoltageWarning;
         FN_RUN:    c = status.running;
         FN_REGEN:  c = !openLoop && status.regenerating;
         FN_OH:     c = status.overheatWarning;
         FN_AGREE:  c = closedLoop && status.ramping && !agr_q;
         FN_TRQ:    c = closedLoop && trq_q;
         FN_TRQLIM: c = closedLoop && status.trqAtLimit;
         FN_OVL:    c = status.overload;
         FN_STOP:   c = status.stopped;
         FN_MC:     c = mcClosed;
         FN_FAN:    c = status.fanWarning;
         FN_LLS:    c = status.lightLoadSearchActive;
         FN_STEADY: c = status.running && !status.ramping;
         FN_BRAKE:  c = status.brakeOpen;
         FN_ELEV1:  c = elevOk && status.elevFlags[0];
         FN_ELEV2:  c = elevOk && status.elevFlags[1];
         FN_ELEV3:  c = elevOk && status.elevFlags[2];
         default:   c = 1'b0;
      endcase
      return c;
   endfunction

   logic [NUM_OUT-1:0] auxD;
   always_comb begin
      for (int i = 0; i < NUM_OUT; i++)
         auxD[i] = condOf(funcSel[i]) ^ polarityInvert[i];
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         auxOutput         <= '0;
         runPermit         <= 1'b0;
         contactorCloseEff <= '0;
         contactorOpenEff  <= '0;
      end else begin
         auxOutput         <= auxD;
         runPermit         <= permitD;
         contactorCloseEff <= closeDly;
         contactorOpenEff  <= openDly;
      end
   end
endmodule : aofs_selector
`default_nettype wire

// file: aofs_selector_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module aofs_selector_assertions
   import aofs_pkg::*;
(
   input wire logic               clk_sys,
   input wire logic               resetn,
   input wire aofs_func_t         funcSel [NUM_OUT],
   input wire logic [NUM_OUT-1:0] polarityInvert,
   input wire aofs_ctrl_mode_t    ctrlMode,
   input wire logic               elevModuleFitted,
   input wire logic               appElevator,
   input wire aofs_status_t       status,
   input wire aofs_cfg_t          cfg,
   input wire logic [NUM_OUT-1:0] auxOutput,
   input wire logic [TIME_W-1:0]  contactorCloseEff,
   input wire logic [TIME_W-1:0]  contactorOpenEff
);
   logic [1:0] upCnt_q;
   // Outputs are held clear until the synchronised reset copy lets go
   wire live = upCnt_q == 2'h3;
   wire openLoop = ctrlMode inside {CM_VF, CM_SLIP};
   wire elevOk = elevModuleFitted & appElevator;
   wire readyNow = status.ready & ~status.faultTrip & (~status.undervoltageWarning | status.batteryRun);
   wire mcUsed = funcSel[0] == FN_MC || funcSel[1] == FN_MC || funcSel[2] == FN_MC
      || funcSel[3] == FN_MC;
   wire [NUM_OUT-1:0] pol = polarityInvert;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) upCnt_q <= 2'h0;
      else if (!live) upCnt_q <= upCnt_q + 2'h1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   AST_UNUSED: assert property (live && funcSel[0] == FN_UNUSED
      |=> auxOutput[0] == $past(pol[0])) else $error("unused drives");
   AST_RUN: assert property (live && funcSel[0] == FN_RUN
      |=> auxOutput[0] == $past(status.running ^ pol[0])) else $error("run");
   AST_READY: assert property (live && funcSel[1] == FN_READY
      |=> auxOutput[1] == $past(readyNow ^ pol[1])) else $error("ready");
   AST_STOP: assert property (live && funcSel[2] == FN_STOP ##1 funcSel[2] == FN_STOP
      |-> auxOutput[2] == ($past(status.stopped) ^ $past(pol[2]))) else $error("stop");
   AST_OH: assert property (live && funcSel[3] == FN_OH
      |=> auxOutput[3] == $past(status.overheatWarning ^ pol[3])) else $error("overheat");
   AST_REGEN_OPEN: assert property (live && funcSel[3] == FN_REGEN && openLoop
      |=> auxOutput[3] == $past(pol[3])) else $error("regen open loop");
   AST_CLOSED_ONLY: assert property (live && openLoop
      && funcSel[1] inside {FN_ZERO, FN_AGREE, FN_TRQ, FN_TRQLIM}
      |=> auxOutput[1] == $past(pol[1])) else $error("closed loop code");
   AST_ELEV: assert property (live && funcSel[2] >= FN_ELEV1 && !elevOk
      |=> auxOutput[2] == $past(pol[2])) else $error("elevator code");
   AST_MC_ZERO: assert property (live && !mcUsed
      |=> contactorCloseEff == '0 && contactorOpenEff == '0) else $error("mc delay");
   AST_MC_EFF: assert property ((live && mcUsed && $stable(cfg)) [*2]
      |-> contactorCloseEff == cfg.contactorCloseDelay
      && contactorOpenEff == cfg.contactorOpenDelay) else $error("mc eff");
endmodule : aofs_selector_assertions
`default_nettype wire

// file: aofs_relay_model.sv
`timescale 1ns/1ps
`default_nettype none
// Contacts follow the coils one clock late, like a relay armature
module aofs_relay_model
   import aofs_pkg::*;
(
   input  wire logic               clk_sys,
   input  wire logic [NUM_OUT-1:0] coil,
   output logic [NUM_OUT-1:0]      contact
);
   initial contact = '0;
   always @(posedge clk_sys) contact <= coil;
endmodule : aofs_relay_model
`default_nettype wire

// file: aofs_selector_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module aofs_selector_tb_top
   import aofs_pkg::*;
;
   localparam int TK = 10;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic fit = 1'b0;
   logic app = 1'b0;
   logic timerIn = 1'b0;
   logic probe = 1'b0;
   logic [NUM_OUT-1:0] pol = '0;
   logic [NUM_OUT-1:0] aux;
   logic [NUM_OUT-1:0] contact;
   logic runPermit;
   logic [TIME_W-1:0] closeEff;
   logic [TIME_W-1:0] openEff;
   aofs_func_t fsel [NUM_OUT] = '{default: FN_UNUSED};
   aofs_ctrl_mode_t mode = CM_SPD_IM;
   aofs_status_t status = '0;
   aofs_meas_t meas = '0;
   aofs_cfg_t cfg = '0;
   logic [NUM_OUT-1:0] expQ [$];
   int num_errors = 0;
   int checked = 0;
   int seed = 32'hbb85eb19;
   always #10 clk_sys = ~clk_sys;
   aofs_selector #(.TICK_CYCLES(TK)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
      .funcSel(fsel), .polarityInvert(pol), .ctrlMode(mode), .elevModuleFitted(fit),
      .appElevator(app), .status(status), .meas(meas), .cfg(cfg), .timerInput(timerIn),
      .auxOutput(aux), .runPermit(runPermit), .contactorCloseEff(closeEff),
      .contactorOpenEff(openEff));
   aofs_relay_model u_relay (.clk_sys(clk_sys), .coil(aux), .contact(contact));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic want(input logic [NUM_OUT-1:0] e);
      expQ.push_back(e);
      probe <= 1'b1;
      cyc(1);
      probe <= 1'b0;
      cyc(1);
   endtask : want
   task automatic setAll(input aofs_func_t c);
      foreach (fsel[i]) fsel[i] <= c;
   endtask : setAll
   task automatic close_out;
      $display("checked=%0d num_errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic waitFor(input bit onPermit, input logic lvl, output int n);
      n = 0;
      while ((onPermit ? runPermit : aux[0]) !== lvl) begin
         cyc(1);
         n++;
         if (n > 12000) begin
            num_errors++;
            close_out();
         end
      end
   endtask : waitFor
   function automatic logic fx(input aofs_func_t c, input aofs_status_t s);
      case (c)
         FN_READY: fx = s.ready & ~s.faultTrip & (~s.undervoltageWarning | s.batteryRun);
         FN_UV: fx = s.undervoltageWarning;
         FN_RUN: fx = s.running;
         FN_REGEN: fx = s.regenerating;
         FN_OH: fx = s.overheatWarning;
         FN_TRQLIM: fx = s.trqAtLimit;
         FN_OVL: fx = s.overload;
         FN_STOP: fx = s.stopped;
         FN_FAN: fx = s.fanWarning;
         FN_LLS: fx = s.lightLoadSearchActive;
         FN_STEADY: fx = s.running & ~s.ramping;
         default: fx = 1'b0;
      endcase
   endfunction : fx
   always @(posedge clk_sys) begin
      if (probe === 1'b1) cmp(16'(aux), 16'(expQ.pop_front()));
   end
   initial begin : stim
      aofs_func_t dir [11] = '{FN_READY, FN_UV, FN_RUN, FN_REGEN, FN_OH, FN_TRQLIM,
         FN_OVL, FN_STOP, FN_FAN, FN_LLS, FN_STEADY};
      aofs_func_t bad [10] = '{FN_ZERO, FN_AGREE, FN_TRQ, FN_TRQLIM, FN_REGEN,
         FN_ELEV1, FN_ELEV2, FN_ELEV3, FN_UNUSED, aofs_func_t'(5'h1f)};
      logic signed [15:0] spd [5] = '{16'sh041a, 16'sh041b, -16'sh03fc, 16'sh03b6, 16'sh03b5};
      logic [3:0] bandExp [5] = '{4'hf, 4'h8, 4'ha, 4'hf, 4'h8};
      logic [31:0] r;
      int n;
      cyc(5);
      resetn <= 1'b1;
      cyc(4);
      want(4'h0);
      foreach (dir[k]) repeat (6) begin
         r = $random(seed);
         status <= r[17:0];
         pol <= r[31:28];
         setAll(dir[k]);
         cyc(2);
         want({4{fx(dir[k], r[17:0])}} ^ r[31:28]);
      end
      $display("test direct done");
      mode <= CM_VF;
      app <= 1'b1;
      status <= '1;
      pol <= 4'h5;
      foreach (bad[k]) begin
         setAll(bad[k]);
         cyc(2);
         want(4'h5);
      end
      $display("test refused done");
      mode <= CM_SPD_IM;
      status <= '0;
      pol <= 4'h0;
      fsel <= '{FN_SPDSGN, FN_SPDABS, FN_ARRIVE, FN_TRQ};
      meas.maxSpeedSetting <= 16'h2710;
      meas.speedRef <= 16'sh03e8;
      cfg.speedThreshold <= 16'sh03e8;
      cfg.speedThresholdBand <= 16'h0005;
      cfg.arrivalBand <= 16'h0005;
      foreach (spd[k]) begin
         meas.motorSpeed <= spd[k];
         cyc(2 * TK + 4);
         want(bandExp[k]);
      end
      $display("test band done");
      fsel[0] <= FN_TIMER;
      cfg.timerAssertDelay <= 16'h0001;
      cfg.timerReleaseDelay <= 16'h0001;
      cyc(2 * TK);
      timerIn <= 1'b1;
      waitFor(1'b0, 1'b1, n);
      cmp(16'(n >= 9980 && n <= 10040), 16'h0001);
      timerIn <= 1'b0;
      waitFor(1'b0, 1'b0, n);
      cmp(16'(n >= 9980 && n <= 10040), 16'h0001);
      $display("test timer done");
      fsel[0] <= FN_MC;
      cfg.contactorCloseDelay <= 16'h0064;
      cfg.contactorOpenDelay <= 16'h0064;
      cyc(4);
      cmp(closeEff, 16'h0064);
      status.runCommand <= 1'b1;
      cyc(2);
      want(4'h9);
      waitFor(1'b1, 1'b1, n);
      cmp(16'(contact[0]), 16'h0001);
      cmp(16'(n >= 9980 && n <= 10040), 16'h0001);
      status.runCommand <= 1'b0;
      waitFor(1'b0, 1'b0, n);
      cmp(16'(n >= 9980 && n <= 10040), 16'h0001);
      setAll(FN_UNUSED);
      cyc(4);
      cmp(closeEff, 16'h0000);
      cmp(openEff, 16'h0000);
      $display("test contactor done");
      close_out();
   end
endmodule : aofs_selector_tb_top
bind aofs_selector aofs_selector_assertions u_chk (.clk_sys(clk_sys), .resetn(resetn),
   .funcSel(funcSel), .polarityInvert(polarityInvert), .ctrlMode(ctrlMode),
   .elevModuleFitted(elevModuleFitted), .appElevator(appElevator), .status(status),
   .cfg(cfg), .auxOutput(auxOutput), .contactorCloseEff(contactorCloseEff),
   .contactorOpenEff(contactorOpenEff));
`default_nettype wire
